// [rtl/adcsq_defs.svh]
// constants for the converter sequence control block
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH
`define ADCSQ_AW              5
`define ADCSQ_OFF_CTRL1       5'h00
`define ADCSQ_OFF_CTRL2       5'h01
`define ADCSQ_OFF_IRQ_STAT    5'h02
`define ADCSQ_OFF_IRQ_MASK    5'h03
`define ADCSQ_OFF_SCAN_SEL    5'h04
`define ADCSQ_OFF_BUF_BASE    5'h10
`define ADCSQ_CTRL1_WMASK     16'h80E7
`define ADCSQ_CTRL2_WMASK     16'hE43F
`define ADCSQ_RESET16         16'h0000
`define ADCSQ_B_ON            15
`define ADCSQ_B_AUTO          2
`define ADCSQ_B_SAMPLE_ENABLE_BIT          1
`define ADCSQ_B_DONE          0
`define ADCSQ_B_SCAN          10
`define ADCSQ_B_BUFFER_FILL_STATUS          7
`define ADCSQ_B_SPLIT         1
`define ADCSQ_B_ALT           0
`define ADCSQ_TRIG_MANUAL     3'h0
`define ADCSQ_TRIG_PIN        3'h1
`define ADCSQ_TRIG_TIMER      3'h2
`define ADCSQ_IRQ_SEQ         0
`define ADCSQ_IRQ_PIN_ERR     1
`define ADCSQ_SYNC_STAGES     3
`endif

// [rtl/adcsq_pkg.sv]
// types for the converter sequence control block
package adcsq_pkg;
  typedef struct packed {
    logic       track;      // high while the sample-and-hold tracks
    logic       start;      // one-cycle conversion start
    logic       mux_b;      // high when setting b is used
    logic       scan;       // positive input steps through scan list
    logic [3:0] scan_ch;    // current scan channel
    logic [1:0] ref_sel;    // bit1 external minus, bit0 external plus
  } adcsq_core_ctl_t;
  typedef struct packed {
    logic       done;       // one-cycle conversion finished
    logic [9:0] data;       // conversion result
  } adcsq_core_res_t;
  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_TRACK, ADCSQ_CONV} adcsq_state_t;
endpackage

// [rtl/adcsq_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module adcsq_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output var  logic level
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lvl_q;
  logic       lvl_d;
  // shift, accept once stages two and three agree
  always_comb begin
    sh_d  = {sh_q[1:0], pin};
    lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q  <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      sh_q  <= sh_d;
      lvl_q <= lvl_d;
    end
  end
  assign level = lvl_q;
endmodule
`default_nettype wire

// [rtl/adcsq_rbuf.sv]
// sixteen-word result buffer, cleared when the module is off
`timescale 1ns/1ps
`default_nettype none
module adcsq_rbuf (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       wr,
  input  wire logic [3:0] wr_idx,
  input  wire logic [9:0] wr_data,
  input  wire logic [3:0] rd_idx,
  output var  logic [9:0] rd_data
);
  logic [9:0] mem_q [16];
  logic [9:0] mem_d [16];
  // off clears every word, else store on write
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!enable) begin
        mem_d[i] = 10'h000;
      end else if (wr && (wr_idx == 4'(i))) begin
        mem_d[i] = wr_data;
      end else begin
        mem_d[i] = mem_q[i];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) mem_q[i] <= 10'h000;
    end else begin
      for (int i = 0; i < 16; i++) mem_q[i] <= mem_d[i];
    end
  end
  assign rd_data = mem_q[rd_idx];
endmodule
`default_nettype wire

// [rtl/adcsq_top.sv]
// converter sequence control: registers, trigger, sequencing, buffer, interrupt
// Notes on behaviour
// - trigger field: 010 timer compare, 001 pin edge ends sampling; 000 manual, 011 to 111 reserved
// - result buffer contents are lost when the module is switched off
// - reference field: 000 supplies, 001 ext plus, 010 ext minus, 011 both, 1xx supplies
// - scan bit steps setting a positive input through the scan list
// - fill status reads 1 while upper half fills, 0 while lower half fills
// - interrupt rate n raises the interrupt every n+1 sequences
// - split mode uses two alternate eight-word halves, else one sixteen-word buffer
// - alternate bit: first sample setting a, then b and a alternate
// - unimplemented control register bits read as zero
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`include "adcsq_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module adcsq_top
  import adcsq_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic [4:0]            addr,
  input  wire logic [15:0]           wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output var  logic [15:0]           rdata,
  input  wire logic                  timer_three_match,
  input  wire logic                  external_interrupt_pin_zero,
  output var  adcsq_pkg::adcsq_core_ctl_t core_ctl,
  input  wire adcsq_pkg::adcsq_core_res_t core_res,
  output var  logic                  irq
);
  import adcsq_pkg::*;

  // reset release through two flops
  logic [1:0] rst_sh_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sh_q <= 2'b00;
    end else begin
      rst_sh_q <= {rst_sh_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sh_q[1];

  // pin synchroniser and edge detect
  logic pin_lvl;
  logic pin_prev_q;
  adcsq_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (external_interrupt_pin_zero),
    .level (pin_lvl)
  );
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_lvl;
    end
  end

  // register state
  logic [15:0]    ctrl1_q, ctrl1_d;
  logic [15:0]    ctrl2_q, ctrl2_d;
  logic [1:0]     stat_q, stat_d;
  logic [1:0]     mask_q, mask_d;
  logic [15:0]    scan_q, scan_d;
  adcsq_state_t   st_q, st_d;
  logic [3:0]     seq_cnt_q, seq_cnt_d;
  logic [3:0]     wr_ptr_q, wr_ptr_d;
  logic           buffer_fill_status_q, buffer_fill_status_d;
  logic           alt_b_q, alt_b_d;
  logic [3:0]     scan_ch_q, scan_ch_d;
  logic           start_q, start_d;
  logic [15:0]    rdata_q, rdata_d;
  logic           irq_q, irq_d;
  logic [9:0]     buf_rd;

  logic module_on, auto_start, sample_enable_bit, split_mode, alt_mode, scan_mode;
  logic [2:0] trig_sel;
  logic [2:0] ref_sel;
  logic [3:0] rate;
  logic       w1, w2, trig_hit, seq_end;
  assign module_on  = ctrl1_q[`ADCSQ_B_ON];
  assign auto_start = ctrl1_q[`ADCSQ_B_AUTO];
  assign sample_enable_bit       = ctrl1_q[`ADCSQ_B_SAMPLE_ENABLE_BIT];
  assign trig_sel   = ctrl1_q[7:5];
  assign ref_sel    = ctrl2_q[15:13];
  assign scan_mode  = ctrl2_q[`ADCSQ_B_SCAN];
  assign rate       = ctrl2_q[5:2];
  assign split_mode = ctrl2_q[`ADCSQ_B_SPLIT];
  assign alt_mode   = ctrl2_q[`ADCSQ_B_ALT];
  assign w1 = wr_en && (addr == `ADCSQ_OFF_CTRL1);
  assign w2 = wr_en && (addr == `ADCSQ_OFF_CTRL2);

  // trigger selection; reserved codes never trigger
  always_comb begin
    unique case (trig_sel)
      `ADCSQ_TRIG_TIMER: trig_hit = timer_three_match;
      `ADCSQ_TRIG_PIN:   trig_hit = pin_lvl && !pin_prev_q;
      default:           trig_hit = 1'b0;
    endcase
  end
  assign seq_end = (st_q == ADCSQ_CONV) && core_res.done;

  // control registers, sequencer, buffer pointers
  always_comb begin
    ctrl1_d   = ctrl1_q;
    ctrl2_d   = ctrl2_q;
    st_d      = st_q;
    seq_cnt_d = seq_cnt_q;
    wr_ptr_d  = wr_ptr_q;
    buffer_fill_status_d    = buffer_fill_status_q;
    alt_b_d   = alt_b_q;
    scan_ch_d = scan_ch_q;
    start_d   = 1'b0;
    scan_d    = scan_q;
    stat_d    = stat_q;
    mask_d    = mask_q;
    irq_d     = 1'b0;
    if (w1) begin
      ctrl1_d = wdata & `ADCSQ_CTRL1_WMASK;
    end
    if (w2) begin
      ctrl2_d = (wdata & `ADCSQ_CTRL2_WMASK) | (ctrl2_q & ~`ADCSQ_CTRL2_WMASK);
    end
    if (wr_en && (addr == `ADCSQ_OFF_SCAN_SEL)) scan_d = wdata;
    if (wr_en && (addr == `ADCSQ_OFF_IRQ_MASK)) mask_d = wdata[1:0];
    if (wr_en && (addr == `ADCSQ_OFF_IRQ_STAT)) stat_d = stat_q & ~wdata[1:0];
    // flag the sample bit being set together with a reserved trigger code
    if (w1 && (wdata[7:5] > `ADCSQ_TRIG_TIMER) && wdata[`ADCSQ_B_SAMPLE_ENABLE_BIT]) stat_d[`ADCSQ_IRQ_PIN_ERR] = 1'b1;
    if (!module_on) begin
      st_d      = ADCSQ_IDLE;
      seq_cnt_d = 4'h0;
      wr_ptr_d  = 4'h0;
      buffer_fill_status_d    = 1'b0;
      alt_b_d   = 1'b0;
      scan_ch_d = 4'h0;
    end else begin
      unique case (st_q)
        ADCSQ_IDLE: begin
          if (ctrl1_d[`ADCSQ_B_SAMPLE_ENABLE_BIT]) begin
            st_d = ADCSQ_TRACK;
            ctrl1_d[`ADCSQ_B_DONE] = 1'b0;
          end
        end
        ADCSQ_TRACK: begin
          if (trig_hit) begin
            ctrl1_d[`ADCSQ_B_SAMPLE_ENABLE_BIT] = 1'b0;
          end
          if (!ctrl1_d[`ADCSQ_B_SAMPLE_ENABLE_BIT]) begin
            st_d    = ADCSQ_CONV;
            start_d = 1'b1;
          end
        end
        ADCSQ_CONV: begin
          if (core_res.done) begin
            ctrl1_d[`ADCSQ_B_DONE] = 1'b1;
            // split mode moves to the start of the other half after the last word of the active half
            if (split_mode && wr_ptr_q[2:0] == 3'h7) begin
              wr_ptr_d = {~buffer_fill_status_q, 3'h0};
              buffer_fill_status_d   = ~buffer_fill_status_q;
            end else begin
              wr_ptr_d = wr_ptr_q + 4'h1;
            end
            alt_b_d = alt_mode ? ~alt_b_q : 1'b0;
            if (scan_mode && !alt_b_q) begin
              scan_ch_d = scan_ch_q + 4'h1;
              for (int k = 15; k >= 0; k--) begin
                if (scan_q[k] && 4'(k) > scan_ch_q) scan_ch_d = 4'(k);
              end
              if (scan_ch_d == scan_ch_q + 4'h1 && !scan_q[scan_ch_d]) scan_ch_d = 4'h0;
            end
            if (seq_cnt_q >= rate) begin
              seq_cnt_d = 4'h0;
              stat_d[`ADCSQ_IRQ_SEQ] = 1'b1;
            end else begin
              seq_cnt_d = seq_cnt_q + 4'h1;
            end
            if (auto_start) begin
              ctrl1_d[`ADCSQ_B_SAMPLE_ENABLE_BIT] = 1'b1;
              ctrl1_d[`ADCSQ_B_DONE] = 1'b0;
              st_d = ADCSQ_TRACK;
            end else begin
              st_d = ADCSQ_IDLE;
            end
          end
        end
      endcase
    end
    if (!split_mode) buffer_fill_status_d = 1'b0;
    if (!alt_mode) alt_b_d = 1'b0;
    irq_d = |(stat_d & mask_d);
  end

  // read mux, data one cycle after strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_en) begin
      if (addr == `ADCSQ_OFF_CTRL1) begin
        rdata_d = ctrl1_q;
      end else if (addr == `ADCSQ_OFF_CTRL2) begin
        rdata_d = ctrl2_q;
        rdata_d[`ADCSQ_B_BUFFER_FILL_STATUS] = buffer_fill_status_q;
      end else if (addr == `ADCSQ_OFF_IRQ_STAT) begin
        rdata_d = {14'h0000, stat_q};
      end else if (addr == `ADCSQ_OFF_IRQ_MASK) begin
        rdata_d = {14'h0000, mask_q};
      end else if (addr == `ADCSQ_OFF_SCAN_SEL) begin
        rdata_d = scan_q;
      end else if (addr[4]) begin
        rdata_d = {6'h00, buf_rd};
      end
    end
  end

  adcsq_rbuf u_rbuf (
    .clk     (clk),
    .rst_n   (rst_n),
    .enable  (module_on),
    .wr      (seq_end),
    .wr_idx  (wr_ptr_q),
    .wr_data (core_res.data),
    .rd_idx  (addr[3:0]),
    .rd_data (buf_rd)
  );

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_q   <= `ADCSQ_RESET16;
      ctrl2_q   <= `ADCSQ_RESET16;
      stat_q    <= 2'b00;
      mask_q    <= 2'b00;
      scan_q    <= `ADCSQ_RESET16;
      st_q      <= ADCSQ_IDLE;
      seq_cnt_q <= 4'h0;
      wr_ptr_q  <= 4'h0;
      buffer_fill_status_q    <= 1'b0;
      alt_b_q   <= 1'b0;
      scan_ch_q <= 4'h0;
      start_q   <= 1'b0;
      rdata_q   <= 16'h0000;
      irq_q     <= 1'b0;
    end else begin
      ctrl1_q   <= ctrl1_d;
      ctrl2_q   <= ctrl2_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      scan_q    <= scan_d;
      st_q      <= st_d;
      seq_cnt_q <= seq_cnt_d;
      wr_ptr_q  <= wr_ptr_d;
      buffer_fill_status_q    <= buffer_fill_status_d;
      alt_b_q   <= alt_b_d;
      scan_ch_q <= scan_ch_d;
      start_q   <= start_d;
      rdata_q   <= rdata_d;
      irq_q     <= irq_d;
    end
  end

  // core control outputs, registered
  adcsq_core_ctl_t ctl_q, ctl_d;
  always_comb begin
    ctl_d.track   = (st_d == ADCSQ_TRACK);
    ctl_d.start   = start_d;
    ctl_d.mux_b   = alt_b_d;
    ctl_d.scan    = ctrl2_d[`ADCSQ_B_SCAN] && !alt_b_d;
    ctl_d.scan_ch = scan_ch_d;
    // 1xx falls back to supplies
    ctl_d.ref_sel = ctrl2_d[15] ? 2'b00 : ctrl2_d[14:13];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= ctl_d;
    end
  end
  assign core_ctl = ctl_q;
  assign rdata    = rdata_q;
  assign irq      = irq_q;
endmodule
`default_nettype wire

// [tb/adcsq_props.sv]
// assertions for the converter sequence control block
`timescale 1ns/1ps
`default_nettype none
module adcsq_props
  import adcsq_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       arst_n,
  input wire logic [4:0]                 addr,
  input wire logic [15:0]                wdata,
  input wire logic                       wr_en,
  input wire logic                       rd_en,
  input wire logic [15:0]                rdata,
  input wire logic                       timer_three_match,
  input wire logic                       external_interrupt_pin_zero,
  input wire adcsq_pkg::adcsq_core_ctl_t core_ctl,
  input wire adcsq_pkg::adcsq_core_res_t core_res,
  input wire logic                       irq
);
  logic [15:0] c1_q;
  logic [15:0] c2_q;
  // shadow of the software-written control words
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c1_q <= 16'h0000;
      c2_q <= 16'h0000;
    end else if (wr_en && addr == 5'h00) begin
      c1_q <= wdata;
    end else if (wr_en && addr == 5'h01) begin
      c2_q <= wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_rd_only; rdata != 16'h0000 |-> $past(rd_en); endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data outside read slot");
  property p_timer;
    timer_three_match && core_ctl.track && c1_q[7:5] == 3'h2 && !wr_en |=> core_ctl.start && !core_ctl.track;
  endproperty
  a_timer: assert property (p_timer) else $error("timer compare did not start conversion");
  property p_resv;
    timer_three_match && core_ctl.track && c1_q[7:6] != 2'b00 && c1_q[7:5] != 3'h2 && !wr_en |=> core_ctl.track;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved trigger ended sampling");
  property p_start; core_ctl.start |-> !core_ctl.track ##1 !core_ctl.start; endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");
  property p_auto; core_res.done && c1_q[15] && c1_q[2] && !wr_en |-> ##[1:3] core_ctl.track; endproperty
  a_auto: assert property (p_auto) else $error("auto start did not resume sampling");
  property p_noalt; core_ctl.start && !c2_q[0] |-> !core_ctl.mux_b; endproperty
  a_noalt: assert property (p_noalt) else $error("setting b used without alternate mode");
  property p_ref;
    c1_q[15] && !wr_en && !$past(wr_en) |-> core_ctl.ref_sel == (c2_q[15] ? 2'b00 : c2_q[14:13]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select mismatch");
  property p_scan;
    c1_q[15] && !wr_en && !$past(wr_en) |-> core_ctl.scan == (c2_q[10] && !core_ctl.mux_b);
  endproperty
  a_scan: assert property (p_scan) else $error("scan flag mismatch");
  property p_mask; wr_en && addr == 5'h03 && wdata == 16'h0000 |-> ##3 !irq; endproperty
  a_mask: assert property (p_mask) else $error("interrupt high while fully masked");
endmodule
bind adcsq_top adcsq_props adcsq_props_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .timer_three_match(timer_three_match),
  .external_interrupt_pin_zero(external_interrupt_pin_zero), .core_ctl(core_ctl), .core_res(core_res), .irq(irq));
`default_nettype wire

// [tb/adcsq_core_model.sv]
// behavioural conversion core answering start pulses
`timescale 1ns/1ps
`default_nettype none
module adcsq_core_model
  import adcsq_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       slow,
  input  wire logic [9:0]                 val,
  input  wire adcsq_pkg::adcsq_core_ctl_t ctl,
  output var  adcsq_pkg::adcsq_core_res_t res
);
  logic [2:0] cnt_q;
  // done after 2 or 6 cycles; data toggles when not valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      res   <= '0;
    end else begin
      res.done <= (cnt_q == 3'h1);
      res.data <= (cnt_q == 3'h1) ? val : ~res.data;
      if (ctl.start) begin
        cnt_q <= slow ? 3'h6 : 3'h2;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/adcsq_top_test.sv]
// self-checking bench for the converter sequence control block
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_test;
  import adcsq_pkg::*;
  logic            clk = 1'b0;
  logic            arst_n = 1'b0;
  logic [4:0]      addr = 5'h00;
  logic [15:0]     wdata = 16'h0000;
  logic            wr_en = 1'b0;
  logic            rd_en = 1'b0;
  logic            tm = 1'b0;
  logic            pin = 1'b0;
  logic            slow = 1'b0;
  logic [9:0]      val = 10'h000;
  logic [15:0]     rdata;
  logic            irq;
  logic            mb;
  adcsq_core_ctl_t core_ctl;
  adcsq_core_res_t core_res;
  int              err_count = 0;
  int              cmp_count = 0;
  always #2.5 clk = ~clk;
  adcsq_top adcsq_top_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .timer_three_match(tm), .external_interrupt_pin_zero(pin), .core_ctl(core_ctl),
    .core_res(core_res), .irq(irq));
  adcsq_core_model adcsq_core_model_i (.clk(clk), .rst_n(arst_n), .slow(slow), .val(val), .ctl(core_ctl),
    .res(core_res));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input string s);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(s, e, rdata);
  endtask
  // one conversion by timer (t=1) or pin (t=0); m is mux_b at start
  task automatic conv(input logic [9:0] v, input logic t, output logic m);
    int n;
    m = 1'bx;
    @(posedge clk);
    val <= v;
    tm  <= t;
    pin <= !t;
    @(posedge clk);
    tm <= 1'b0;
    for (n = 0; n < 40; n++) begin
      #1;
      if (core_ctl.start === 1'b1) begin
        m = core_ctl.mux_b;
        pin <= 1'b0;
      end
      if (core_res.done === 1'b1) break;
      @(posedge clk);
    end
    if (n == 40) begin
      err_count++;
      close_out;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    rd(5'h01, 16'h0000, "ctrl2");
    wr(5'h00, 16'h7F18);
    rd(5'h00, 16'h0000, "ctrl1");
    wr(5'h00, 16'h8000);
    wr(5'h01, 16'hFFFF);
    rd(5'h01, 16'hE43F, "ctrl2 gaps");
    chk("scan", 16'h0001, {15'h0, core_ctl.scan});
    rd(5'h08, 16'h0000, "unmapped");
    for (int v = 0; v < 8; v++) begin
      wr(5'h01, {v[2:0], 13'h0000});
      rd(5'h01, {v[2:0], 13'h0000}, "vref");
      chk("ref_sel", {14'h0, v[2] ? 2'b00 : v[1:0]}, {14'h0, core_ctl.ref_sel});
    end
    chk("scan", 16'h0000, {15'h0, core_ctl.scan});
  endtask
  task automatic t_trig;
    wr(5'h03, 16'h0001);
    for (int c = 3; c < 8; c++) begin
      wr(5'h00, {8'h80, c[2:0], 5'h02});
      @(posedge clk);
      tm <= 1'b1;
      @(posedge clk);
      tm <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("reserved", 16'h0001, {15'h0, core_ctl.track});
    end
    wr(5'h00, 16'h8042);
    chk("track", 16'h0001, {15'h0, core_ctl.track});
    conv(10'h155, 1'b1, mb);
    chk("hold", 16'h0000, {15'h0, core_ctl.track});
    rd(5'h00, 16'h8041, "done");
    rd(5'h10, 16'h0155, "word0");
    chk("irq", 16'h0001, {15'h0, irq});
    rd(5'h02, 16'h0003, "status");
    wr(5'h03, 16'h0000);
    rd(5'h02, 16'h0003, "status");
    chk("masked", 16'h0000, {15'h0, irq});
    wr(5'h02, 16'h0003);
    wr(5'h03, 16'h0001);
    wr(5'h00, 16'h8022);
    conv(10'h2AA, 1'b0, mb);
    rd(5'h00, 16'h8021, "pin done");
    wr(5'h00, 16'h8022);
    rd(5'h00, 16'h8022, "done cleared");
    wr(5'h02, 16'h0001);
  endtask
  task automatic t_rate;
    wr(5'h00, 16'h0000);
    wr(5'h01, 16'h040C);
    wr(5'h04, 16'h0005);
    wr(5'h00, 16'h8046);
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      chk("irq early", 16'h0000, {15'h0, irq});
      conv(10'h100 + 10'(i), 1'b1, mb);
      chk("scan_ch", {12'h000, i[0] ? 4'h0 : 4'h2}, {12'h000, core_ctl.scan_ch});
      chk("auto", 16'h0001, {15'h0, core_ctl.track});
      chk("mux_b", 16'h0000, {15'h0, mb});
    end
    chk("irq", 16'h0001, {15'h0, irq});
    rd(5'h13, 16'h0103, "word3");
    wr(5'h02, 16'h0001);
    slow <= 1'b0;
  endtask
  task automatic t_split;
    wr(5'h00, 16'h0000);
    wr(5'h01, 16'h001F);
    wr(5'h00, 16'h8046);
    for (int i = 0; i < 9; i++) begin
      if (i == 8) rd(5'h01, 16'h009F, "fill status");
      conv(10'h200 + 10'(i), 1'b1, mb);
      chk("alt mux_b", {15'h0, i[0]}, {15'h0, mb});
    end
    rd(5'h18, 16'h0208, "upper half");
    rd(5'h10, 16'h0200, "lower half");
    wr(5'h00, 16'h0000);
    rd(5'h10, 16'h0000, "cleared");
    rd(5'h01, 16'h001F, "fill reset");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_trig;
    t_rate;
    t_split;
    close_out;
  end
endmodule
`default_nettype wire
